/* pfc_cfg.svh */
// constants of the port function configuration block
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH
`define PFC_NPORTS 12
`define PFC_IDX_W 4
`define PFC_WORD_W 16
`define PFC_FSEL_HI 15
`define PFC_FSEL_LO 12
`define PFC_PRM_B11 11
`define PFC_MODE_HIZ 4'h0
`define PFC_MODE_GPI 4'h1
`define PFC_MODE_XLAT 4'h2
`define PFC_NO_XLAT_A 4'h5
`define PFC_NO_XLAT_B 4'hB
`define PFC_CFG_RST 16'h0000
`define PFC_CLK_MHZ 50
`define PFC_SETTLE_US 1000
`define PFC_SETTLE_CYC (`PFC_CNT_W'(`PFC_SETTLE_US * `PFC_CLK_MHZ))
`define PFC_CNT_W 16
`define PFC_CNT_ONE 16'h0001
`endif

/* pfc_pkg.sv */
// types of the port function configuration block
package pfc_pkg;
  typedef enum logic [1:0] {
    PFC_ST_READY = 2'b01,
    PFC_ST_SETTLE = 2'b10
  } pfc_settle_t;
  typedef logic [15:0] pfc_word_t;
endpackage

/* pfc_path_if.sv */
// carrier between the configuration bank and one port's input path
`timescale 1ns/1ps
`default_nettype none
interface pfc_path_if;
  logic enable;
  logic thr_wr;
  logic cmp_raw;
  logic mask;
  logic evmode;
  logic level;
  logic event_p;
  logic settling;
  modport ctl (output enable, output thr_wr, output cmp_raw, output mask, output evmode,
    input level, input event_p, input settling);
  modport path (input enable, input thr_wr, input cmp_raw, input mask, input evmode,
    output level, output event_p, output settling);
endinterface
`default_nettype wire

/* pfc_input_path.sv */
// one port's digital input path with threshold settling
`timescale 1ns/1ps
`default_nettype none
`include "pfc_cfg.svh"
module pfc_input_path
  import pfc_pkg::*;
#(
  parameter logic [`PFC_CNT_W-1:0] SETTLE_CYC = `PFC_SETTLE_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  pfc_path_if.path pif
);
  pfc_settle_t st_r, st_nxt;
  logic [`PFC_CNT_W-1:0] cnt_r, cnt_nxt;
  logic level_r, level_nxt;
  logic event_r, event_nxt;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    level_nxt = level_r;
    event_nxt = 1'b0;
    case (st_r)
      PFC_ST_READY: begin
        // compare result only trusted once the threshold has settled
        if (pif.enable) begin
          level_nxt = pif.cmp_raw;
        end else begin
          level_nxt = 1'b0;
        end
      end
      PFC_ST_SETTLE: begin
        // old level held while enabled, cleared when disabled; a new write restarts the wait below
        if (cnt_r <= `PFC_CNT_ONE) begin
          st_nxt = PFC_ST_READY;
        end else begin
          cnt_nxt = cnt_r - `PFC_CNT_ONE;
        end
        if (!pif.enable) begin
          level_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt = PFC_ST_READY;
      end
    endcase
    if (pif.thr_wr) begin
      st_nxt = PFC_ST_SETTLE;
      cnt_nxt = SETTLE_CYC;
    end
    // masked ports never flag a change, so a host can reconfigure quietly
    event_nxt = pif.enable && (level_nxt != level_r) && !pif.mask && pif.evmode;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_r <= PFC_ST_READY;
      cnt_r <= '0;
      level_r <= 1'b0;
      event_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      level_r <= level_nxt;
      event_r <= event_nxt;
    end
  end

  assign pif.level = level_r;
  assign pif.event_p = event_r;
  assign pif.settling = (st_r == PFC_ST_SETTLE);
endmodule // pfc_input_path
`default_nettype wire

/* pfc_port_function_config.sv */
// per-port function configuration bank for twelve mixed-signal ports
// How it works
// - every port 0 to 11 has a 4-bit function select in bits 15:12 of its config word.
// - select 0000 puts the port in high impedance with no function active.
// - select 0001 makes a digital input reporting one when the pin exceeds its threshold.
// - a newly written threshold may take up to 1 ms to become effective.
// - the comparison result is readable in the port's bit of the input level register.
// - select 0010 on the lower port of a pair links the pair as a two-way translator.
// - a translator port shows its activity through its digital input path.
// - parameter bit 11 picks the converter reference: 0 internal, 1 the DAC reference.
// - parameter bit 11 set inverts forwarded input data, clear passes it unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "pfc_cfg.svh"
module pfc_port_function_config
  import pfc_pkg::*;
#(
  parameter logic [`PFC_CNT_W-1:0] SETTLE_CYC = `PFC_SETTLE_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cfg_wr_en,
  input wire logic cfg_rd_en,
  input wire logic [`PFC_IDX_W-1:0] cfg_port,
  input wire logic [`PFC_WORD_W-1:0] cfg_wdata,
  output logic [`PFC_WORD_W-1:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic thr_wr_en,
  input wire logic [`PFC_IDX_W-1:0] thr_port,
  input wire logic [`PFC_NPORTS-1:0] cmp_above,
  input wire logic [`PFC_NPORTS-1:0] input_event_mask,
  input wire logic [`PFC_NPORTS-1:0] input_event_mode,
  output logic [`PFC_NPORTS-1:0] input_level_value,
  output logic [`PFC_NPORTS-1:0] input_event,
  output logic [`PFC_NPORTS-1:0] thr_settling,
  output logic [`PFC_NPORTS-1:0] port_hiz,
  output logic [`PFC_NPORTS-1:0] port_gpi_en,
  output logic [`PFC_NPORTS-1:0] xlat_link_en,
  output logic [`PFC_NPORTS-1:0] adc_ref_select,
  output logic [`PFC_NPORTS-1:0] forward_data
);
  pfc_word_t cfg_r [`PFC_NPORTS];
  pfc_word_t cfg_nxt [`PFC_NPORTS];
  logic [`PFC_WORD_W-1:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [`PFC_NPORTS-1:0] hiz_r, hiz_nxt;
  logic [`PFC_NPORTS-1:0] gpi_r, gpi_nxt;
  logic [`PFC_NPORTS-1:0] xlat_r, xlat_nxt;
  logic [`PFC_NPORTS-1:0] aref_r, aref_nxt;
  logic [`PFC_NPORTS-1:0] fwd_r, fwd_nxt;
  logic [`PFC_NPORTS-1:0] level_w, event_w, settle_w;

  function automatic logic [3:0] fn_fsel(input pfc_word_t w);
    fn_fsel = w[`PFC_FSEL_HI:`PFC_FSEL_LO];
  endfunction

  // ports 5 and 11 have no upper partner, so the link is refused there
  function automatic logic fn_xlat(input pfc_word_t w, input logic [`PFC_IDX_W-1:0] idx);
    fn_xlat = (fn_fsel(w) == `PFC_MODE_XLAT) && (idx != `PFC_NO_XLAT_A)
      && (idx != `PFC_NO_XLAT_B);
  endfunction

  function automatic logic fn_in_path(input pfc_word_t w, input logic [`PFC_IDX_W-1:0] idx);
    fn_in_path = (fn_fsel(w) == `PFC_MODE_GPI) || fn_xlat(w, idx);
  endfunction

  // port index decode, shared by the word write and the threshold write
  function automatic logic fn_port_hit(input logic [`PFC_IDX_W-1:0] sel,
    input logic [`PFC_IDX_W-1:0] idx);
    fn_port_hit = (sel == idx);
  endfunction

  // configuration words and read port
  always_comb begin
    for (int i = 0; i < `PFC_NPORTS; i++) begin
      cfg_nxt[i] = cfg_r[i];
      if (cfg_wr_en && fn_port_hit(cfg_port, i[`PFC_IDX_W-1:0])) begin
        cfg_nxt[i] = cfg_wdata;
      end
    end
    rvalid_nxt = cfg_rd_en;
    rdata_nxt = '0;
    if (cfg_rd_en && (cfg_port < `PFC_IDX_W'(`PFC_NPORTS))) begin
      rdata_nxt = cfg_r[cfg_port];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < `PFC_NPORTS; i++) begin
        cfg_r[i] <= `PFC_CFG_RST;
      end
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end else begin
      for (int i = 0; i < `PFC_NPORTS; i++) begin
        cfg_r[i] <= cfg_nxt[i];
      end
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // mode decode, registered so the pin controls never glitch on a write
  always_comb begin
    for (int i = 0; i < `PFC_NPORTS; i++) begin
      hiz_nxt[i] = (fn_fsel(cfg_r[i]) == `PFC_MODE_HIZ);
      gpi_nxt[i] = fn_in_path(cfg_r[i], i[`PFC_IDX_W-1:0]);
      xlat_nxt[i] = fn_xlat(cfg_r[i], i[`PFC_IDX_W-1:0]);
      aref_nxt[i] = cfg_r[i][`PFC_PRM_B11];
      fwd_nxt[i] = level_w[i] ^ cfg_r[i][`PFC_PRM_B11];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      hiz_r <= '1;
      gpi_r <= '0;
      xlat_r <= '0;
      aref_r <= '0;
      fwd_r <= '0;
    end else begin
      hiz_r <= hiz_nxt;
      gpi_r <= gpi_nxt;
      xlat_r <= xlat_nxt;
      aref_r <= aref_nxt;
      fwd_r <= fwd_nxt;
    end
  end

  // one input path per port
  for (genvar g = 0; g < `PFC_NPORTS; g++) begin : g_path
    pfc_path_if pif ();
    assign pif.enable = gpi_r[g];
    assign pif.thr_wr = thr_wr_en && fn_port_hit(thr_port, `PFC_IDX_W'(g));
    assign pif.cmp_raw = cmp_above[g];
    assign pif.mask = input_event_mask[g];
    assign pif.evmode = input_event_mode[g];
    assign level_w[g] = pif.level;
    assign event_w[g] = pif.event_p;
    assign settle_w[g] = pif.settling;
    pfc_input_path #(
      .SETTLE_CYC(SETTLE_CYC)
    ) u_path (
      .mclk(mclk),
      .srst(srst),
      .pif(pif)
    );
  end

  assign cfg_rdata = rdata_r;
  assign cfg_rvalid = rvalid_r;
  assign input_level_value = level_w;
  assign input_event = event_w;
  assign thr_settling = settle_w;
  assign port_hiz = hiz_r;
  assign port_gpi_en = gpi_r;
  assign xlat_link_en = xlat_r;
  assign adc_ref_select = aref_r;
  assign forward_data = fwd_r;
endmodule // pfc_port_function_config
`default_nettype wire

/* pfc_chk.sv */
// assertions on the port function configuration bank ports
`timescale 1ns/1ps
`default_nettype none
module pfc_chk (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cfg_wr_en,
  input wire logic cfg_rd_en,
  input wire logic [3:0] cfg_port,
  input wire logic [15:0] cfg_wdata,
  input wire logic [15:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic thr_wr_en,
  input wire logic [3:0] thr_port,
  input wire logic [11:0] cmp_above,
  input wire logic [11:0] input_level_value,
  input wire logic [11:0] input_event_mask,
  input wire logic [11:0] input_event_mode,
  input wire logic [11:0] input_event,
  input wire logic [11:0] thr_settling,
  input wire logic [11:0] port_hiz,
  input wire logic [11:0] port_gpi_en,
  input wire logic [11:0] xlat_link_en,
  input wire logic [11:0] adc_ref_select,
  input wire logic [11:0] forward_data
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_cfg(logic [3:0] m);
    cfg_wr_en && cfg_port < 4'hC && cfg_wdata[15:12] == m;
  endsequence
  sequence s_settle;
    thr_settling[1] [*8];
  endsequence
  property p_rv; cfg_rd_en |=> cfg_rvalid; endproperty
  property p_unmap; cfg_rd_en && cfg_port > 4'hB |=> cfg_rdata == 16'h0000; endproperty
  property p_hiz; s_cfg(4'h0) |-> ##2 port_hiz[$past(cfg_port, 2)]; endproperty
  property p_gpi; s_cfg(4'h1) |-> ##2 port_gpi_en[$past(cfg_port, 2)]; endproperty
  property p_xl;
    s_cfg(4'h2) ##0 cfg_port != 4'h5 && cfg_port != 4'hB |-> ##2 xlat_link_en[$past(cfg_port, 2)];
  endproperty
  property p_xg; (xlat_link_en & ~port_gpi_en) == 12'h000; endproperty
  property p_set; thr_wr_en && thr_port == 4'h1 |=> s_settle; endproperty
  property p_lvl;
    1'b1 |=> ((input_level_value ^ $past(cmp_above)) & $past(port_gpi_en & ~thr_settling)) == 12'h000;
  endproperty
  property p_ref;
    cfg_wr_en && cfg_port < 4'hC |-> ##2 adc_ref_select[$past(cfg_port, 2)] == $past(cfg_wdata[11], 2);
  endproperty
  property p_evt;
    1'b1 |=> (input_event & ($past(input_event_mask) | ~$past(input_event_mode)
      | ~(input_level_value ^ $past(input_level_value)))) == 12'h000;
  endproperty
  property p_fwd;
    $stable(adc_ref_select) |-> forward_data == ($past(input_level_value) ^ adc_ref_select);
  endproperty
  a_rv: assert property (p_rv) else $error("no read valid");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_hiz: assert property (p_hiz) else $error("not high impedance");
  a_gpi: assert property (p_gpi) else $error("input not enabled");
  a_xl: assert property (p_xl) else $error("translator not linked");
  a_xg: assert property (p_xg) else $error("translator without input path");
  a_set: assert property (p_set) else $error("settling too short");
  a_lvl: assert property (p_lvl) else $error("level not following compare");
  a_ref: assert property (p_ref) else $error("reference select wrong");
  a_fwd: assert property (p_fwd) else $error("forward data wrong");
  a_evt: assert property (p_evt) else $error("event without unmasked level change");
endmodule // pfc_chk
bind pfc_port_function_config pfc_chk u_chk (.mclk, .srst, .cfg_wr_en, .cfg_rd_en, .cfg_port,
  .cfg_wdata, .cfg_rdata, .cfg_rvalid, .thr_wr_en, .thr_port, .cmp_above, .input_level_value,
  .input_event_mask, .input_event_mode, .input_event,
  .thr_settling, .port_hiz, .port_gpi_en, .xlat_link_en, .adc_ref_select, .forward_data);
`default_nettype wire

/* pfc_host_model.sv */
// host model issuing configuration word writes and reads
`timescale 1ns/1ps
`default_nettype none
module pfc_host_model (
  input wire logic mclk,
  output logic cfg_wr_en = 1'b0,
  output logic cfg_rd_en = 1'b0,
  output logic [3:0] cfg_port = 4'h0,
  output logic [15:0] cfg_wdata = 16'h0000,
  input wire logic [15:0] cfg_rdata,
  input wire logic cfg_rvalid
);
  task automatic wr(input logic [3:0] p, input logic [15:0] d);
    @(posedge mclk) #1;
    cfg_wr_en = 1'b1;
    cfg_port = p;
    cfg_wdata = d;
    @(posedge mclk) #1;
    cfg_wr_en = 1'b0;
    cfg_wdata = ~d; // released data does not keep its last value
  endtask
  // always parks the port in high impedance first
  task automatic set_mode(input logic [3:0] p, input logic [15:0] d);
    wr(p, 16'h0000);
    wr(p, d);
  endtask
  task automatic rd(input logic [3:0] p, output logic [15:0] d, output logic v);
    @(posedge mclk) #1;
    cfg_rd_en = 1'b1;
    cfg_port = p;
    @(posedge mclk) #1;
    cfg_rd_en = 1'b0;
    d = cfg_rdata;
    v = cfg_rvalid;
  endtask
endmodule // pfc_host_model
`default_nettype wire

/* pfc_port_function_config_bench.sv */
// self-checking bench for the port function configuration bank
`timescale 1ns/1ps
`default_nettype none
module pfc_port_function_config_bench;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic thr_wr_en = 1'b0;
  logic [3:0] thr_port = 4'h0;
  logic [11:0] cmp_above = 12'h000;
  logic [11:0] input_event_mask = 12'hFFF;
  logic [11:0] input_event_mode = 12'h000;
  logic cfg_wr_en, cfg_rd_en, cfg_rvalid, rv;
  logic [3:0] cfg_port;
  logic [15:0] cfg_wdata, cfg_rdata, rd_w;
  logic [11:0] input_level_value, input_event, thr_settling, port_hiz, port_gpi_en;
  logic [11:0] xlat_link_en, adc_ref_select, forward_data;
  int n_mismatch = 0;
  int tests_run = 0;
  int k;
  always #10 mclk = ~mclk;
  pfc_host_model host (.mclk, .cfg_wr_en, .cfg_rd_en, .cfg_port, .cfg_wdata, .cfg_rdata,
    .cfg_rvalid);
  pfc_port_function_config #(.SETTLE_CYC(16'h0014)) uut (.mclk, .srst, .cfg_wr_en, .cfg_rd_en,
    .cfg_port, .cfg_wdata, .cfg_rdata, .cfg_rvalid, .thr_wr_en, .thr_port, .cmp_above,
    .input_event_mask, .input_event_mode, .input_level_value, .input_event, .thr_settling,
    .port_hiz, .port_gpi_en, .xlat_link_en, .adc_ref_select, .forward_data);
  // modes cycle 0,1,2; ports 5 and 11 kept out of translator mode
  function automatic logic [15:0] wd(input int i);
    return {(i == 5 || i == 11) ? 4'h0 : 4'(i % 3), i[0], 7'h00, i[3:0]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    #1 srst = 1'b0;
    chk(port_hiz, 16'h0FFF);
    for (int i = 0; i < 12; i++) host.set_mode(i[3:0], wd(i));
    host.wr(4'hC, 16'h1FFF);
    host.rd(4'hC, rd_w, rv);
    chk(rd_w, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      host.rd(i[3:0], rd_w, rv);
      chk(rd_w, wd(i));
      chk(rv, 1'b1);
    end
    chk(port_hiz, 16'h0A69);
    chk(port_gpi_en, 16'h0596);
    chk(xlat_link_en, 16'h0104);
    chk(adc_ref_select, 16'h0AAA);
    cmp_above = 12'h5A5;
    @(posedge mclk) #1;
    chk(input_event, 12'h000);
    repeat (2) @(posedge mclk) #1;
    chk(input_level_value, 12'h5A5 & 12'h596);
    chk(forward_data, (12'h5A5 & 12'h596) ^ 12'hAAA);
    thr_wr_en = 1'b1; // masked before the threshold write
    thr_port = 4'h1;
    @(posedge mclk) #1;
    thr_wr_en = 1'b0;
    cmp_above[1] = 1'b1;
    repeat (5) @(posedge mclk) #1;
    chk(thr_settling[1], 1'b1);
    chk(input_level_value[1], 1'b0);
    for (k = 0; k < 60 && thr_settling[1] !== 1'b0; k++) @(posedge mclk) #1;
    chk(thr_settling[1], 1'b0);
    repeat (2) @(posedge mclk) #1;
    chk(input_level_value[1], 1'b1);
    input_event_mode[1] = 1'b1;
    @(posedge mclk) #1;
    input_event_mask[1] = 1'b0;
    @(posedge mclk) #1;
    chk(input_event, 12'h000);
    cmp_above[1] = 1'b0;
    @(posedge mclk) #1;
    chk(input_event, 12'h002);
    chk(input_level_value[1], 1'b0);
    @(posedge mclk) #1;
    chk(input_event, 12'h000);
    print_verdict();
  end
endmodule // pfc_port_function_config_bench
`default_nettype wire
